// [rtl/rcss_defs.svh]
`ifndef RCSS_DEFS_SVH
`define RCSS_DEFS_SVH

// System clock period in nanoseconds (40 MHz).
`define RCSS_CLK_PERIOD_NS 25

// Oscillator start-up delays, worst case, in nanoseconds.
`define RCSS_TOSCD_FAST_RC_NS 1100
`define RCSS_TOSCD_LOW_POWER_RC_NS 70000
`define RCSS_TOSCD_CRYSTAL_NS 70000

// PLL lock interval, nominal, in nanoseconds.
`define RCSS_TLOCK_NS 1500000

// Start-up timer length in periods of the oscillator's own clock.
`define RCSS_OST_PERIODS 1024

// PLL multiplication factor, and the factor reported when the PLL is not used.
`define RCSS_PLL_FACTOR 3'h4
`define RCSS_NO_PLL_FACTOR 3'h1

// Current-oscillator field position in the oscillator control word.
`define RCSS_CURRENT_OSC_SELECT_LSB 12
`define RCSS_CURRENT_OSC_SELECT_MSB 14

// Clock selection of an erased configuration word, also the reset value.
`define RCSS_ERASED_SEL 3'h7

`endif

// [rtl/rcss_pkg.sv]
package rcss_pkg;

   // Codes of the new-oscillator configuration field.
   typedef enum logic [2:0] {
      RCSS_NOSC_FAST_RC       = 3'h0,
      RCSS_NOSC_FAST_RC_MULT  = 3'h1,
      RCSS_NOSC_PRIMARY       = 3'h2,
      RCSS_NOSC_PRIMARY_MULT  = 3'h3,
      RCSS_NOSC_SECONDARY     = 3'h4,
      RCSS_NOSC_LOW_POWER_RC  = 3'h5,
      RCSS_NOSC_FAST_RC_DIV16 = 3'h6,
      RCSS_NOSC_FAST_RC_DIV_N = 3'h7
   } rcss_nosc_t;

   // Codes of the primary type field.
   typedef enum logic [1:0] {
      RCSS_PT_EXTERNAL = 2'h0,
      RCSS_PT_MEDIUM   = 2'h1,
      RCSS_PT_HIGH     = 2'h2,
      RCSS_PT_SPARE    = 2'h3
   } rcss_ptype_t;

   // Resolved oscillator modes.
   typedef enum logic [3:0] {
      RCSS_M_FAST_RC        = 4'h0,
      RCSS_M_FAST_RC_DIV16  = 4'h1,
      RCSS_M_FAST_RC_DIV_N  = 4'h2,
      RCSS_M_FAST_RC_MULT   = 4'h3,
      RCSS_M_MEDIUM_XTAL    = 4'h4,
      RCSS_M_HIGH_XTAL      = 4'h5,
      RCSS_M_EXTERNAL       = 4'h6,
      RCSS_M_MEDIUM_MULT    = 4'h7,
      RCSS_M_EXTERNAL_MULT  = 4'h8,
      RCSS_M_SECONDARY      = 4'h9,
      RCSS_M_LOW_POWER_RC   = 4'hA
   } rcss_mode_t;

   // Start-up sequencer states.
   typedef enum logic [2:0] {
      RCSS_S_SUPPLY = 3'h0,
      RCSS_S_OSCD   = 3'h1,
      RCSS_S_OST    = 3'h2,
      RCSS_S_LOCK   = 3'h3,
      RCSS_S_RUN    = 3'h4
   } rcss_state_t;

   // Kind of oscillator start-up delay.
   typedef enum logic [1:0] {
      RCSS_D_FAST_RC   = 2'h0,
      RCSS_D_LOW_POWER = 2'h1,
      RCSS_D_CRYSTAL   = 2'h2
   } rcss_dkind_t;

   // Stored clock configuration.
   typedef struct packed {
      rcss_nosc_t  new_osc_select;
      rcss_ptype_t primary_type_field;
      logic        second_pin_function_bit;
      logic        erased;
   } rcss_cfg_t;

   // Steps that a mode needs before it is ready.
   typedef struct packed {
      logic        oscd;
      logic        ost;
      logic        pll;
      rcss_dkind_t kind;
   } rcss_plan_t;

   // Oscillator enables toward the analog blocks.
   typedef struct packed {
      logic fast_rc;
      logic low_power_rc;
      logic primary;
      logic secondary;
      logic pll;
   } rcss_osc_en_t;

endpackage : rcss_pkg

// [rtl/rcss_ost_counter.sv]
`timescale 1ns/1ps
`include "rcss_defs.svh"

// Counts periods of the oscillator's own clock after a start request.
module rcss_ost_counter
   import rcss_pkg::*;
(
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_b,
   // Oscillator clock from the pad.
   input  wire logic osc_clk_pin,
   // Control.
   input  wire logic start,
   output logic      done
);

   logic        sync_a;
   logic        sync_b;
   logic        prev;
   logic        busy;
   logic [10:0] cnt;
   wire         rise;
   wire         last;

   // The pad clock is slow against clk, so its edges are found after two flops.
   assign rise = sync_b & ~prev;
   assign last = busy & rise & (cnt == 11'(`RCSS_OST_PERIODS - 1));

   // Synchroniser and edge history.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev   <= 1'b0;
      end else begin
         sync_a <= osc_clk_pin;
         sync_b <= sync_a;
         prev   <= sync_b;
      end
   end

   // Period counter; a new start always restarts from zero.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy <= 1'b0;
         cnt  <= 11'h000;
         done <= 1'b0;
      end else begin
         busy <= start | (busy & ~last);
         cnt  <= start ? 11'h000 : ((busy & rise) ? cnt + 11'h001 : cnt);
         done <= last & ~start;
      end
   end

   AST_OST_PERIODS: assert property (@(posedge clk) disable iff (!rst_b)
      done |-> $past(cnt) == 11'(`RCSS_OST_PERIODS - 1) && $past(rise) && $past(busy))
      else $error("Start-up timer ended on a wrong period count.");

   AST_OST_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
      start |=> busy && cnt == 11'h000 && !done)
      else $error("Start-up timer did not restart.");

endmodule : rcss_ost_counter

// [rtl/rcss_top.sv]
`timescale 1ns/1ps
`include "rcss_defs.svh"

module rcss_top
   import rcss_pkg::*;
#(
   parameter int PLL_LOCK_CYCLES =
      (`RCSS_TLOCK_NS + `RCSS_CLK_PERIOD_NS - 1) / `RCSS_CLK_PERIOD_NS
)
(
   // Clock and reset.
   input  wire logic   clk,
   input  wire logic   rst_b,
   // Reset sources and supply monitor, all from pads.
   input  wire logic   power_on_event,
   input  wire logic   brownout_reset,
   input  wire logic   warm_reset_event,
   input  wire logic   supply_stable,
   // Oscillator clock from the pad, used by the start-up timer.
   input  wire logic   osc_clk_pin,
   // Stored configuration.
   input  wire rcss_cfg_t cfg,
   // Reset and clock status.
   output logic        device_reset_b,
   output logic [15:0] oscillator_control_reg,
   output rcss_osc_en_t osc_en,
   output logic [2:0]  pll_factor,
   output logic        instr_clk,
   // Second oscillator pin.
   output logic        second_pin_out,
   output logic        second_pin_oe,
   output logic        second_pin_gpio_en
);

   localparam int FAST_RC_CYC =
      `RCSS_TOSCD_FAST_RC_NS / `RCSS_CLK_PERIOD_NS;
   localparam int LOW_POWER_CYC =
      `RCSS_TOSCD_LOW_POWER_RC_NS / `RCSS_CLK_PERIOD_NS;
   localparam int CRYSTAL_CYC =
      `RCSS_TOSCD_CRYSTAL_NS / `RCSS_CLK_PERIOD_NS;

   // Resolve a configuration code and primary type into a mode.
   function automatic rcss_mode_t mode_of(input rcss_nosc_t sel, input rcss_ptype_t pt);
      rcss_mode_t m;
      m = RCSS_M_FAST_RC_DIV_N;
      unique case (sel)
         RCSS_NOSC_FAST_RC:       m = RCSS_M_FAST_RC;
         RCSS_NOSC_FAST_RC_MULT:  m = RCSS_M_FAST_RC_MULT;
         RCSS_NOSC_SECONDARY:     m = RCSS_M_SECONDARY;
         RCSS_NOSC_LOW_POWER_RC:  m = RCSS_M_LOW_POWER_RC;
         RCSS_NOSC_FAST_RC_DIV16: m = RCSS_M_FAST_RC_DIV16;
         RCSS_NOSC_FAST_RC_DIV_N: m = RCSS_M_FAST_RC_DIV_N;
         RCSS_NOSC_PRIMARY: begin
            // The spare type code is treated as an external clock.
            if (pt == RCSS_PT_MEDIUM) m = RCSS_M_MEDIUM_XTAL;
            else if (pt == RCSS_PT_HIGH) m = RCSS_M_HIGH_XTAL;
            else m = RCSS_M_EXTERNAL;
         end
         RCSS_NOSC_PRIMARY_MULT: begin
            // The high-speed crystal has no multiplied form and runs plain.
            if (pt == RCSS_PT_MEDIUM) m = RCSS_M_MEDIUM_MULT;
            else if (pt == RCSS_PT_HIGH) m = RCSS_M_HIGH_XTAL;
            else m = RCSS_M_EXTERNAL_MULT;
         end
      endcase
      return m;
   endfunction : mode_of

   // Steps that bring a mode to readiness.
   function automatic rcss_plan_t plan_of(input rcss_mode_t m);
      rcss_plan_t p;
      p = '{oscd: 1'b1, ost: 1'b0, pll: 1'b0, kind: RCSS_D_FAST_RC};
      unique case (m)
         RCSS_M_FAST_RC, RCSS_M_FAST_RC_DIV16, RCSS_M_FAST_RC_DIV_N: ;
         RCSS_M_FAST_RC_MULT: p.pll = 1'b1;
         RCSS_M_MEDIUM_XTAL, RCSS_M_HIGH_XTAL, RCSS_M_SECONDARY: begin
            p.ost  = 1'b1;
            p.kind = RCSS_D_CRYSTAL;
         end
         RCSS_M_MEDIUM_MULT: begin
            p.ost  = 1'b1;
            p.pll  = 1'b1;
            p.kind = RCSS_D_CRYSTAL;
         end
         RCSS_M_EXTERNAL: p.oscd = 1'b0;
         RCSS_M_EXTERNAL_MULT: begin
            p.oscd = 1'b0;
            p.pll  = 1'b1;
         end
         RCSS_M_LOW_POWER_RC: p.kind = RCSS_D_LOW_POWER;
         default: p.oscd = 1'b1;
      endcase
      return p;
   endfunction : plan_of

   // Counter load for the start-up delay, one less than its length.
   function automatic logic [15:0] oscd_load(input rcss_dkind_t k);
      logic [15:0] v;
      v = 16'(FAST_RC_CYC - 1);
      if (k == RCSS_D_LOW_POWER) v = 16'(LOW_POWER_CYC - 1);
      else if (k == RCSS_D_CRYSTAL) v = 16'(CRYSTAL_CYC - 1);
      return v;
   endfunction : oscd_load

   // First state after a given point of the sequence.
   function automatic rcss_state_t step_after(input rcss_plan_t p, input logic [1:0] from);
      rcss_state_t s;
      s = RCSS_S_RUN;
      if (from == 2'h0 && p.oscd) s = RCSS_S_OSCD;
      else if (from <= 2'h1 && p.ost) s = RCSS_S_OST;
      else if (p.pll) s = RCSS_S_LOCK;
      return s;
   endfunction : step_after

   rcss_state_t state;
   rcss_state_t next_state;
   rcss_nosc_t  act_sel;
   rcss_ptype_t act_pt;
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic [3:0]  sync_a;
   logic [3:0]  sync_b;
   logic        cold_pending;
   logic        ost_done;

   wire         cold_src;
   wire         warm_src;
   wire         supply_ok;
   wire         src_any;
   wire         go;
   wire         cnt_zero;
   wire         ost_start;
   wire         need_pin;
   wire         clkout_sel;
   rcss_nosc_t  load_sel;
   rcss_plan_t  load_plan;
   rcss_plan_t  act_plan;
   rcss_mode_t  act_mode;

   // Pad inputs pass two flops; only the second stage is looked at.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_a <= 4'h0;
         sync_b <= 4'h0;
      end else begin
         sync_a <= {supply_stable, warm_reset_event, brownout_reset, power_on_event};
         sync_b <= sync_a;
      end
   end

   // Source decode and the configuration that a cold reset would load.
   assign cold_src  = sync_b[0] | sync_b[1];
   assign warm_src  = sync_b[2];
   assign supply_ok = sync_b[3];
   assign src_any   = cold_src | warm_src;
   assign go        = (state == RCSS_S_SUPPLY) & ~src_any & supply_ok;
   assign load_sel  = cfg.erased ? rcss_nosc_t'(`RCSS_ERASED_SEL)
                                 : cfg.new_osc_select;
   assign load_plan = plan_of(mode_of(load_sel, cfg.primary_type_field));
   assign act_mode  = mode_of(act_sel, act_pt);
   assign act_plan  = plan_of(act_mode);
   assign cnt_zero  = (cnt == 16'h0000);
   assign ost_start = (next_state == RCSS_S_OST) & (state != RCSS_S_OST);

   // Sequencer; a reset source or a supply drop always returns to the hold state.
   always_comb begin
      next_state = state;
      next_cnt   = cnt_zero ? cnt : cnt - 16'h0001;
      if (src_any | ~supply_ok) begin
         next_state = RCSS_S_SUPPLY;
      end else begin
         unique case (state)
            RCSS_S_SUPPLY: begin
               if (cold_pending) next_state = step_after(load_plan, 2'h0);
               else next_state = RCSS_S_RUN;
               if (cold_pending && load_plan.oscd) next_cnt = oscd_load(load_plan.kind);
               else if (cold_pending && load_plan.pll) next_cnt = 16'(PLL_LOCK_CYCLES - 1);
            end
            RCSS_S_OSCD: begin
               if (cnt_zero) next_state = step_after(act_plan, 2'h1);
               if (cnt_zero) next_cnt = 16'(PLL_LOCK_CYCLES - 1);
            end
            RCSS_S_OST: begin
               if (ost_done) next_state = step_after(act_plan, 2'h2);
               if (ost_done) next_cnt = 16'(PLL_LOCK_CYCLES - 1);
            end
            RCSS_S_LOCK: begin
               if (cnt_zero) next_state = RCSS_S_RUN;
            end
            RCSS_S_RUN: next_state = RCSS_S_RUN;
            default: next_state = RCSS_S_SUPPLY;
         endcase
      end
   end

   // State, counter and cold marker; the marker lives until release, so a cut start reruns.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state        <= RCSS_S_SUPPLY;
         cnt          <= 16'h0000;
         cold_pending <= 1'b1;
      end else begin
         state        <= next_state;
         cnt          <= next_cnt;
         cold_pending <= cold_src | (cold_pending & (state != RCSS_S_RUN));
      end
   end

   // Active selection changes only when a cold reset is released.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         act_sel <= rcss_nosc_t'(`RCSS_ERASED_SEL);
         act_pt  <= RCSS_PT_EXTERNAL;
      end else if (go && cold_pending) begin
         act_sel <= load_sel;
         act_pt  <= cfg.primary_type_field;
      end
   end

   // Second pin use; primary crystal modes own the pin as the oscillator's output side.
   assign need_pin   = (act_mode == RCSS_M_MEDIUM_XTAL) | (act_mode == RCSS_M_HIGH_XTAL)
                     | (act_mode == RCSS_M_MEDIUM_MULT);
   assign clkout_sel = ~need_pin & ~cfg.second_pin_function_bit;

   // Registered status and clock outputs.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         device_reset_b         <= 1'b0;
         oscillator_control_reg <= {1'b0, `RCSS_ERASED_SEL, 12'h000};
         osc_en                 <= '0;
         pll_factor             <= `RCSS_NO_PLL_FACTOR;
         instr_clk              <= 1'b0;
         second_pin_out         <= 1'b0;
         second_pin_oe          <= 1'b0;
         second_pin_gpio_en     <= 1'b0;
      end else begin
         device_reset_b         <= (next_state == RCSS_S_RUN);
         oscillator_control_reg <= {1'b0, act_sel, 12'h000};
         osc_en.fast_rc         <= act_sel inside {RCSS_NOSC_FAST_RC, RCSS_NOSC_FAST_RC_MULT,
                                                   RCSS_NOSC_FAST_RC_DIV16,
                                                   RCSS_NOSC_FAST_RC_DIV_N};
         osc_en.low_power_rc    <= (act_sel == RCSS_NOSC_LOW_POWER_RC);
         osc_en.primary         <= act_sel inside {RCSS_NOSC_PRIMARY, RCSS_NOSC_PRIMARY_MULT};
         osc_en.secondary       <= (act_sel == RCSS_NOSC_SECONDARY);
         osc_en.pll             <= act_plan.pll;
         pll_factor             <= act_plan.pll ? `RCSS_PLL_FACTOR
                                                : `RCSS_NO_PLL_FACTOR;
         instr_clk              <= device_reset_b & ~instr_clk;
         second_pin_out         <= clkout_sel & instr_clk;
         second_pin_oe          <= clkout_sel;
         second_pin_gpio_en     <= ~need_pin & cfg.second_pin_function_bit;
      end
   end

   // Start-up timer on the oscillator's own clock.
   rcss_ost_counter u_ost (
      .clk         (clk),
      .rst_b       (rst_b),
      .osc_clk_pin (osc_clk_pin),
      .start       (ost_start),
      .done        (ost_done)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence seq_leave_oscd;
      state == RCSS_S_OSCD && cnt_zero && !src_any && supply_ok;
   endsequence

   sequence seq_leave_ost;
      state == RCSS_S_OST && ost_done && !src_any && supply_ok;
   endsequence

   AST_COLD_LOAD: assert property (go && cold_pending && !cfg.erased
      |=> act_sel == $past(cfg.new_osc_select))
      else $error("Cold reset did not load the configured clock.");

   AST_WARM_KEEP: assert property (go && !cold_pending
      |=> $stable(act_sel) && state == RCSS_S_RUN)
      else $error("Warm reset changed the clock or delayed release.");

   AST_SUPPLY_HOLD: assert property (!supply_ok || src_any
      |=> !device_reset_b && state == RCSS_S_SUPPLY)
      else $error("Reset released without stable supply.");

   AST_LOCK_LEN: assert property (state == RCSS_S_LOCK && $past(state) != RCSS_S_LOCK
      |-> cnt == 16'(PLL_LOCK_CYCLES - 1))
      else $error("PLL lock wait has the wrong length.");

   AST_RC_DELAY: assert property (state == RCSS_S_OSCD && $past(state) == RCSS_S_SUPPLY
      && act_mode == RCSS_M_FAST_RC |-> cnt == 16'(FAST_RC_CYC - 1))
      else $error("Fast RC start-up delay has the wrong length.");

   AST_MULT_XTAL: assert property (seq_leave_oscd ##0 act_mode == RCSS_M_MEDIUM_MULT
      |=> state == RCSS_S_OST)
      else $error("Medium crystal PLL skipped the start-up timer.");

   AST_MULT_XTAL_LOCK: assert property (seq_leave_ost ##0 act_plan.pll
      |=> state == RCSS_S_LOCK)
      else $error("PLL mode skipped the lock wait.");

   AST_MULT_RC: assert property (seq_leave_oscd ##0 act_mode == RCSS_M_FAST_RC_MULT
      |=> state == RCSS_S_LOCK)
      else $error("Fast RC PLL did not go to the lock wait.");

   AST_XTAL_RUN: assert property (seq_leave_ost ##0 !act_plan.pll
      |=> state == RCSS_S_RUN && device_reset_b)
      else $error("Crystal mode did not release after the timer.");

   AST_EXT_NOWAIT: assert property (go && cold_pending && !load_plan.oscd
      |=> state == (load_plan.pll ? RCSS_S_LOCK : RCSS_S_RUN))
      else $error("External clock release took a wrong path.");

   AST_INSTR_DIV: assert property (device_reset_b && $past(device_reset_b)
      |-> instr_clk != $past(instr_clk))
      else $error("Instruction clock is not half the oscillator rate.");

   AST_ERASED_SEL: assert property (go && cold_pending && cfg.erased
      |=> act_sel == RCSS_NOSC_FAST_RC_DIV_N ##1
          oscillator_control_reg[`RCSS_CURRENT_OSC_SELECT_MSB:`RCSS_CURRENT_OSC_SELECT_LSB] == 3'h7)
      else $error("Erased device did not default to divided fast RC.");

   AST_PIN_FREE: assert property (second_pin_oe |-> !$past(need_pin))
      else $error("Clock driven on a pin that the crystal needs.");

endmodule : rcss_top

// [sim/rcss_partner.sv]
`timescale 1ns/1ps

// Crystal, external clock source and power supervisor as seen at the pads.
module rcss_partner #(
   parameter int OSC_HALF_NS     = 50,
   parameter int SUPPLY_DELAY_NS = 200
)
(
   // Supervisor control.
   input  wire logic supply_on,
   // Oscillator enable from the block.
   input  wire logic osc_run,
   // Pad levels.
   output wire logic supply_stable,
   output logic      osc_clk_pin
);
   // The supply is reported good only after it has settled.
   assign #(SUPPLY_DELAY_NS) supply_stable = supply_on;

   // The oscillator swings only while enabled, so a timer cannot count a dead part.
   initial begin
      osc_clk_pin = 1'b0;
      forever begin
         #(OSC_HALF_NS);
         osc_clk_pin = osc_run ? ~osc_clk_pin : 1'b0;
      end
   end
endmodule : rcss_partner

// [sim/tb_rcss_top.sv]
`timescale 1ns/1ps

module tb_rcss_top
   import rcss_pkg::*;
;
   localparam int LOCK = 20;
   localparam int XTAL = 2800 + 4096;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic power_on_event = 1'b0;
   logic brownout_reset = 1'b0;
   logic warm_reset_event = 1'b0;
   logic supply_on = 1'b1;
   logic supply_stable;
   logic osc_clk_pin;
   rcss_cfg_t cfg = 7'h00;
   logic device_reset_b;
   logic [15:0] oscillator_control_reg;
   rcss_osc_en_t osc_en;
   logic [2:0] pll_factor;
   logic instr_clk;
   logic second_pin_out;
   logic second_pin_oe;
   logic second_pin_gpio_en;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int n;

   // The lock count is shortened so that each multiplied mode stays quick.
   rcss_top #(.PLL_LOCK_CYCLES(LOCK)) i_dut (
      .clk(clk), .rst_b(rst_b), .power_on_event(power_on_event),
      .brownout_reset(brownout_reset), .warm_reset_event(warm_reset_event),
      .supply_stable(supply_stable), .osc_clk_pin(osc_clk_pin), .cfg(cfg),
      .device_reset_b(device_reset_b), .oscillator_control_reg(oscillator_control_reg),
      .osc_en(osc_en), .pll_factor(pll_factor), .instr_clk(instr_clk),
      .second_pin_out(second_pin_out), .second_pin_oe(second_pin_oe),
      .second_pin_gpio_en(second_pin_gpio_en));

   rcss_partner i_partner (
      .supply_on(supply_on), .osc_run(osc_en.primary | osc_en.secondary),
      .supply_stable(supply_stable), .osc_clk_pin(osc_clk_pin));

   // Clock at 40 MHz and a ceiling well above the longest expected run.
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         num_errors++;
         end_of_test();
      end
   end

   task automatic end_of_test;
      $display("Checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   // Counts cycles until the device leaves reset, bounded against a hang.
   task automatic wait_release(output int cnt);
      cnt = 0;
      while (device_reset_b !== 1'b1 && cnt < 9000) begin
         @(posedge clk);
         #1;
         cnt++;
      end
   endtask : wait_release

   // Checks selection after release; the status lags release by a cycle.
   task automatic check_run(input logic [2:0] ecode, input logic [2:0] epll);
      logic prev;
      logic [4:0] een;
      prev = instr_clk;
      een  = {ecode inside {3'h0, 3'h1, 3'h6, 3'h7}, ecode == 3'h5, ecode inside {3'h2, 3'h3},
              ecode == 3'h4, epll == 3'h4};
      @(posedge clk);
      #1;
      check("instr clk", instr_clk ^ prev, 1'b1);
      @(posedge clk);
      #1;
      check("osc code", oscillator_control_reg, {1'b0, ecode, 12'h000});
      check("pll factor", pll_factor, epll);
      check("osc enables", osc_en, een);
      check("clock out", second_pin_out, second_pin_oe & ~prev);
   endtask : check_run

   task automatic cold_run(input logic [6:0] c, input logic [2:0] ecode, input int dly,
         input logic [2:0] epll, input logic [1:0] epin);
      @(posedge clk);
      rst_b <= 1'b0;
      cfg   <= c;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      wait_release(n);
      check("startup min", n >= dly, 1'b1);
      check("startup max", n <= dly + 16, 1'b1);
      check("pin use", {second_pin_oe, second_pin_gpio_en}, epin);
      check_run(ecode, epll);
   endtask : cold_run

   // Raises one reset source for a few cycles and checks the hold.
   task automatic pulse_src(input int which);
      @(posedge clk);
      warm_reset_event <= (which == 0);
      power_on_event   <= (which == 1);
      brownout_reset   <= (which == 2);
      repeat (4) @(posedge clk);
      #1;
      check("held", device_reset_b, 1'b0);
      @(posedge clk);
      {warm_reset_event, power_on_event, brownout_reset} <= 3'h0;
      wait_release(n);
   endtask : pulse_src

   // Main sequence: every selection code from a cold start, then the reset kinds.
   initial begin
      repeat (4) @(posedge clk);
      check("reset out", device_reset_b, 1'b0);
      check("reset code", oscillator_control_reg, 16'h7000);
      rst_b <= 1'b1;
      cold_run({3'h0, 2'h0, 2'h0}, 3'h0, 44, 3'h1, 2'b10);
      cold_run({3'h1, 2'h0, 2'h0}, 3'h1, 44 + LOCK, 3'h4, 2'b10);
      cold_run({3'h2, 2'h1, 2'h0}, 3'h2, XTAL, 3'h1, 2'b00);
      cold_run({3'h2, 2'h2, 2'h2}, 3'h2, XTAL, 3'h1, 2'b00);
      cold_run({3'h2, 2'h0, 2'h2}, 3'h2, 0, 3'h1, 2'b01);
      cold_run({3'h3, 2'h1, 2'h0}, 3'h3, XTAL + LOCK, 3'h4, 2'b00);
      cold_run({3'h3, 2'h0, 2'h0}, 3'h3, LOCK, 3'h4, 2'b10);
      cold_run({3'h3, 2'h2, 2'h0}, 3'h3, XTAL, 3'h1, 2'b00);
      cold_run({3'h2, 2'h3, 2'h0}, 3'h2, 0, 3'h1, 2'b10);
      cold_run({3'h4, 2'h0, 2'h0}, 3'h4, XTAL, 3'h1, 2'b10);
      cold_run({3'h5, 2'h0, 2'h2}, 3'h5, 2800, 3'h1, 2'b01);
      cold_run({3'h6, 2'h0, 2'h0}, 3'h6, 44, 3'h1, 2'b10);
      cold_run({3'h7, 2'h0, 2'h0}, 3'h7, 44, 3'h1, 2'b10);
      cold_run({3'h0, 2'h0, 2'h1}, 3'h7, 44, 3'h1, 2'b10);
      cfg <= {3'h6, 2'h0, 2'h0};
      pulse_src(0);
      check("warm quick", n <= 8, 1'b1);
      check_run(3'h7, 3'h1);
      pulse_src(1);
      check_run(3'h6, 3'h1);
      cfg <= {3'h5, 2'h0, 2'h0};
      pulse_src(2);
      check("brownout wait", n >= 2800, 1'b1);
      check_run(3'h5, 3'h1);
      supply_on <= 1'b0;
      repeat (16) @(posedge clk);
      #1;
      check("supply hold", device_reset_b, 1'b0);
      supply_on <= 1'b1;
      wait_release(n);
      check("supply back", device_reset_b, 1'b1);
      end_of_test();
   end
endmodule : tb_rcss_top
